// file: common/cis_pkg.sv
package cis_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] CIS_OFS_SELECT = 4'h0;
    localparam logic [3:0] CIS_OFS_MODE = 4'h1;
    localparam logic [15:0] CIS_RST_SELECT = 16'h0000;
    localparam logic [15:0] CIS_RST_MODE = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CIS_POS_SA = 0;
    localparam int CIS_POS_NA_LO = 1;
    localparam int CIS_POS_NA_HI = 2;
    localparam int CIS_POS_SB = 8;
    localparam int CIS_POS_NB_LO = 9;
    localparam int CIS_POS_NB_HI = 10;
    localparam int CIS_POS_TWELVE = 0;
    localparam int CIS_POS_OPMODE1 = 1;
    localparam int CIS_POS_OPMODE2 = 2;
    localparam int CIS_POS_OPMODE3 = 3;
    localparam logic [15:0] CIS_SELECT_MASK = 16'h0707;
    localparam logic [15:0] CIS_MODE_MASK = 16'h000F;

    // ------------------------------------------------------------
    // Routed source codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CIS_SRC_AN0 = 4'h0,
        CIS_SRC_AN1 = 4'h1,
        CIS_SRC_AN2 = 4'h2,
        CIS_SRC_AN3 = 4'h3,
        CIS_SRC_AN6 = 4'h6,
        CIS_SRC_AN7 = 4'h7,
        CIS_SRC_AN8 = 4'h8,
        CIS_SRC_AN9 = 4'h9,
        CIS_SRC_AN10 = 4'hA,
        CIS_SRC_AN11 = 4'hB,
        CIS_SRC_OA1 = 4'hC,
        CIS_SRC_OA2 = 4'hD,
        CIS_SRC_OA3 = 4'hE,
        CIS_SRC_LOW_REFERENCE = 4'hF
    } cis_src_e;

    typedef struct packed {
        logic [3:0] ch1;
        logic [3:0] ch2;
        logic [3:0] ch3;
    } cis_route_s;

endpackage : cis_pkg

// file: core/cis_decode.sv
`timescale 1ns/100ps
module cis_decode (
    input wire logic pos_sel,
    input wire logic [1:0] neg_sel,
    input wire logic [3:1] opamp_on,
    output cis_pkg::cis_route_s pos_route,
    output cis_pkg::cis_route_s neg_route
);
    // ------------------------------------------------------------
    // Shared op-amp / pin choice
    // ------------------------------------------------------------
    logic [3:0] s1_or_3;
    logic [3:0] s2_or_0;
    logic [3:0] s3_or_6;

    assign s1_or_3 = opamp_on[1] ? cis_pkg::CIS_SRC_OA1 : cis_pkg::CIS_SRC_AN3;
    assign s2_or_0 = opamp_on[2] ? cis_pkg::CIS_SRC_OA2 : cis_pkg::CIS_SRC_AN0;
    assign s3_or_6 = opamp_on[3] ? cis_pkg::CIS_SRC_OA3 : cis_pkg::CIS_SRC_AN6;

    always_comb begin
        if (pos_sel) begin
            pos_route = '{ch1: s1_or_3, ch2: s2_or_0, ch3: s3_or_6};
        end else begin
            pos_route = '{ch1: s2_or_0, ch2: cis_pkg::CIS_SRC_AN1, ch3: cis_pkg::CIS_SRC_AN2};
        end
    end

    always_comb begin
        if (neg_sel == 2'h3) begin
            neg_route = '{ch1: cis_pkg::CIS_SRC_AN9, ch2: cis_pkg::CIS_SRC_AN10, ch3: cis_pkg::CIS_SRC_AN11};
        end else if (neg_sel == 2'h2) begin
            neg_route = '{ch1: s3_or_6, ch2: cis_pkg::CIS_SRC_AN7, ch3: cis_pkg::CIS_SRC_AN8};
        end else begin
            neg_route = '{ch1: cis_pkg::CIS_SRC_LOW_REFERENCE, ch2: cis_pkg::CIS_SRC_LOW_REFERENCE,
                          ch3: cis_pkg::CIS_SRC_LOW_REFERENCE};
        end
    end
endmodule : cis_decode

// file: core/cis_select.sv
`timescale 1ns/100ps
module cis_select (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    output cis_pkg::cis_route_s POS_ROUTE_A,
    output cis_pkg::cis_route_s NEG_ROUTE_A,
    output cis_pkg::cis_route_s POS_ROUTE_B,
    output cis_pkg::cis_route_s NEG_ROUTE_B
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] sel_q;
    logic [15:0] mode_q;
    logic [15:0] sel_view;
    logic twelve;
    logic [3:1] opamp_on;
    cis_pkg::cis_route_s pa_d;
    cis_pkg::cis_route_s na_d;
    cis_pkg::cis_route_s pb_d;
    cis_pkg::cis_route_s nb_d;

    assign twelve = mode_q[cis_pkg::CIS_POS_TWELVE];
    assign opamp_on = {mode_q[cis_pkg::CIS_POS_OPMODE3], mode_q[cis_pkg::CIS_POS_OPMODE2],
                       mode_q[cis_pkg::CIS_POS_OPMODE1]};

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sel_q <= cis_pkg::CIS_RST_SELECT;
        end else if (WR && ADDR == cis_pkg::CIS_OFS_SELECT) begin
            sel_q <= WDATA & cis_pkg::CIS_SELECT_MASK;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mode_q <= cis_pkg::CIS_RST_MODE;
        end else if (WR && ADDR == cis_pkg::CIS_OFS_MODE) begin
            mode_q <= WDATA & cis_pkg::CIS_MODE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Twelve-bit masking
    // ------------------------------------------------------------
    always_comb begin
        sel_view = sel_q;
        if (twelve) begin
            sel_view = 16'h0000;
        end
    end

    // Stored bits survive a trip through 12-bit mode
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (RD && ADDR == cis_pkg::CIS_OFS_SELECT) begin
            RDATA <= sel_view;
        end else if (RD && ADDR == cis_pkg::CIS_OFS_MODE) begin
            RDATA <= mode_q;
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    // mux A positive and negative decode
    cis_decode u_dec_a (
        .pos_sel(sel_view[cis_pkg::CIS_POS_SA]),
        .neg_sel(sel_view[cis_pkg::CIS_POS_NA_HI:cis_pkg::CIS_POS_NA_LO]),
        .opamp_on(opamp_on),
        .pos_route(pa_d),
        .neg_route(na_d)
    );

    cis_decode u_dec_b (
        .pos_sel(sel_view[cis_pkg::CIS_POS_SB]),
        .neg_sel(sel_view[cis_pkg::CIS_POS_NB_HI:cis_pkg::CIS_POS_NB_LO]),
        .opamp_on(opamp_on),
        .pos_route(pb_d),
        .neg_route(nb_d)
    );

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            POS_ROUTE_A <= '{ch1: cis_pkg::CIS_SRC_AN0, ch2: cis_pkg::CIS_SRC_AN1, ch3: cis_pkg::CIS_SRC_AN2};
            NEG_ROUTE_A <= '{ch1: cis_pkg::CIS_SRC_LOW_REFERENCE, ch2: cis_pkg::CIS_SRC_LOW_REFERENCE,
                             ch3: cis_pkg::CIS_SRC_LOW_REFERENCE};
            POS_ROUTE_B <= '{ch1: cis_pkg::CIS_SRC_AN0, ch2: cis_pkg::CIS_SRC_AN1, ch3: cis_pkg::CIS_SRC_AN2};
            NEG_ROUTE_B <= '{ch1: cis_pkg::CIS_SRC_LOW_REFERENCE, ch2: cis_pkg::CIS_SRC_LOW_REFERENCE,
                             ch3: cis_pkg::CIS_SRC_LOW_REFERENCE};
        end else begin
            POS_ROUTE_A <= pa_d;
            NEG_ROUTE_A <= na_d;
            POS_ROUTE_B <= pb_d;
            NEG_ROUTE_B <= nb_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_nb_high;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[10:9] == 2'h3) |=> NEG_ROUTE_B.ch3 == cis_pkg::CIS_SRC_AN11;
    endproperty
    a_nb_high: assert property (p_nb_high) else $error("mux B negative 11 misrouted");

    property p_nb_ref;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && !sel_q[10]) |=> NEG_ROUTE_B.ch2 == cis_pkg::CIS_SRC_LOW_REFERENCE;
    endproperty
    a_nb_ref: assert property (p_nb_ref) else $error("mux B negative 0x not low reference");

    property p_twelve_read;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == cis_pkg::CIS_OFS_SELECT && twelve) |=> RDATA == 16'h0000;
    endproperty
    a_twelve_read: assert property (p_twelve_read) else $error("12-bit mode read not zero");

    property p_sb_one;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[8] && opamp_on[1]) |=> POS_ROUTE_B.ch1 == cis_pkg::CIS_SRC_OA1;
    endproperty
    a_sb_one: assert property (p_sb_one) else $error("mux B positive 1 misrouted");

    property p_na_mid;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[2:1] == 2'h2) |=> NEG_ROUTE_A.ch2 == cis_pkg::CIS_SRC_AN7;
    endproperty
    a_na_mid: assert property (p_na_mid) else $error("mux A negative 10 misrouted");

    property p_reserved;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == cis_pkg::CIS_OFS_SELECT) |=> (RDATA & 16'hF8F8) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

    property p_opamp_mode_enable;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && !sel_q[0] && !opamp_on[2]) |=> POS_ROUTE_A.ch1 == cis_pkg::CIS_SRC_AN0;
    endproperty
    a_opamp_mode_enable: assert property (p_opamp_mode_enable) else $error("pin not routed with op-amp off");

    property p_sa;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && !sel_q[0]) |=> POS_ROUTE_A.ch2 == cis_pkg::CIS_SRC_AN1;
    endproperty
    a_sa: assert property (p_sa) else $error("mux A positive 0 misrouted");

    property p_nb_high_rest;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[10:9] == 2'h3) |=> NEG_ROUTE_B.ch1 == cis_pkg::CIS_SRC_AN9 &&
            NEG_ROUTE_B.ch2 == cis_pkg::CIS_SRC_AN10;
    endproperty
    a_nb_high_rest: assert property (p_nb_high_rest) else $error("mux B negative 11 low channels misrouted");

    property p_nb_mid;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[10:9] == 2'h2) |=> NEG_ROUTE_B.ch2 == cis_pkg::CIS_SRC_AN7 &&
            NEG_ROUTE_B.ch3 == cis_pkg::CIS_SRC_AN8;
    endproperty
    a_nb_mid: assert property (p_nb_mid) else $error("mux B negative 10 misrouted");

    property p_nb_mid_amp;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[10:9] == 2'h2 && opamp_on[3]) |=> NEG_ROUTE_B.ch1 == cis_pkg::CIS_SRC_OA3;
    endproperty
    a_nb_mid_amp: assert property (p_nb_mid_amp) else $error("op-amp three not routed");

    property p_nb_mid_pin;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[10:9] == 2'h2 && !opamp_on[3]) |=> NEG_ROUTE_B.ch1 == cis_pkg::CIS_SRC_AN6;
    endproperty
    a_nb_mid_pin: assert property (p_nb_mid_pin) else $error("input six not routed");

    property p_nb_ref_rest;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && !sel_q[10]) |=> NEG_ROUTE_B.ch1 == cis_pkg::CIS_SRC_LOW_REFERENCE &&
            NEG_ROUTE_B.ch3 == cis_pkg::CIS_SRC_LOW_REFERENCE;
    endproperty
    a_nb_ref_rest: assert property (p_nb_ref_rest) else $error("mux B negative 0x outer channels wrong");

    property p_na_high;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[2:1] == 2'h3) |=> NEG_ROUTE_A.ch1 == cis_pkg::CIS_SRC_AN9 &&
            NEG_ROUTE_A.ch2 == cis_pkg::CIS_SRC_AN10 && NEG_ROUTE_A.ch3 == cis_pkg::CIS_SRC_AN11;
    endproperty
    a_na_high: assert property (p_na_high) else $error("mux A negative 11 misrouted");

    property p_na_mid_rest;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[2:1] == 2'h2) |=> NEG_ROUTE_A.ch3 == cis_pkg::CIS_SRC_AN8;
    endproperty
    a_na_mid_rest: assert property (p_na_mid_rest) else $error("mux A negative 10 channel 3 wrong");

    property p_na_ref;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && !sel_q[2]) |=> NEG_ROUTE_A.ch1 == cis_pkg::CIS_SRC_LOW_REFERENCE &&
            NEG_ROUTE_A.ch2 == cis_pkg::CIS_SRC_LOW_REFERENCE && NEG_ROUTE_A.ch3 == cis_pkg::CIS_SRC_LOW_REFERENCE;
    endproperty
    a_na_ref: assert property (p_na_ref) else $error("mux A negative 0x not low reference");

    property p_sb_zero;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && !sel_q[8]) |=> POS_ROUTE_B.ch2 == cis_pkg::CIS_SRC_AN1 &&
            POS_ROUTE_B.ch3 == cis_pkg::CIS_SRC_AN2;
    endproperty
    a_sb_zero: assert property (p_sb_zero) else $error("mux B positive 0 misrouted");

    property p_sb_zero_amp;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && !sel_q[8] && opamp_on[2]) |=> POS_ROUTE_B.ch1 == cis_pkg::CIS_SRC_OA2;
    endproperty
    a_sb_zero_amp: assert property (p_sb_zero_amp) else $error("op-amp two not routed");

    property p_sb_pins;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[8] && opamp_on == 3'h0) |=> POS_ROUTE_B.ch1 == cis_pkg::CIS_SRC_AN3 &&
            POS_ROUTE_B.ch2 == cis_pkg::CIS_SRC_AN0 && POS_ROUTE_B.ch3 == cis_pkg::CIS_SRC_AN6;
    endproperty
    a_sb_pins: assert property (p_sb_pins) else $error("mux B positive 1 pins misrouted");

    property p_sb_amps;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[8] && opamp_on == 3'h7) |=> POS_ROUTE_B.ch1 == cis_pkg::CIS_SRC_OA1 &&
            POS_ROUTE_B.ch2 == cis_pkg::CIS_SRC_OA2 && POS_ROUTE_B.ch3 == cis_pkg::CIS_SRC_OA3;
    endproperty
    a_sb_amps: assert property (p_sb_amps) else $error("mux B positive 1 op-amps misrouted");

    property p_sa_pins;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[0] && opamp_on == 3'h0) |=> POS_ROUTE_A.ch1 == cis_pkg::CIS_SRC_AN3 &&
            POS_ROUTE_A.ch2 == cis_pkg::CIS_SRC_AN0 && POS_ROUTE_A.ch3 == cis_pkg::CIS_SRC_AN6;
    endproperty
    a_sa_pins: assert property (p_sa_pins) else $error("mux A positive 1 pins misrouted");

    property p_sa_amps;
        @(posedge CLK_SYS) disable iff (RST)
        (!twelve && sel_q[0] && opamp_on == 3'h7) |=> POS_ROUTE_A.ch1 == cis_pkg::CIS_SRC_OA1 &&
            POS_ROUTE_A.ch2 == cis_pkg::CIS_SRC_OA2 && POS_ROUTE_A.ch3 == cis_pkg::CIS_SRC_OA3;
    endproperty
    a_sa_amps: assert property (p_sa_amps) else $error("mux A positive 1 op-amps misrouted");

    property p_twelve_pos_a;
        @(posedge CLK_SYS) disable iff (RST)
        twelve |=> POS_ROUTE_A.ch2 == cis_pkg::CIS_SRC_AN1 && POS_ROUTE_A.ch3 == cis_pkg::CIS_SRC_AN2;
    endproperty
    a_twelve_pos_a: assert property (p_twelve_pos_a) else $error("12-bit mode mux A positive not zero code");

    property p_twelve_neg_a;
        @(posedge CLK_SYS) disable iff (RST)
        twelve |=> NEG_ROUTE_A.ch1 == cis_pkg::CIS_SRC_LOW_REFERENCE && NEG_ROUTE_A.ch3 == cis_pkg::CIS_SRC_LOW_REFERENCE;
    endproperty
    a_twelve_neg_a: assert property (p_twelve_neg_a) else $error("12-bit mode mux A negative not zero code");

    property p_twelve_pos_b;
        @(posedge CLK_SYS) disable iff (RST)
        twelve |=> POS_ROUTE_B.ch2 == cis_pkg::CIS_SRC_AN1 && POS_ROUTE_B.ch3 == cis_pkg::CIS_SRC_AN2;
    endproperty
    a_twelve_pos_b: assert property (p_twelve_pos_b) else $error("12-bit mode mux B positive not zero code");

    property p_twelve_neg_b;
        @(posedge CLK_SYS) disable iff (RST)
        twelve |=> NEG_ROUTE_B.ch1 == cis_pkg::CIS_SRC_LOW_REFERENCE && NEG_ROUTE_B.ch3 == cis_pkg::CIS_SRC_LOW_REFERENCE;
    endproperty
    a_twelve_neg_b: assert property (p_twelve_neg_b) else $error("12-bit mode mux B negative not zero code");

    property p_sel_read;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == cis_pkg::CIS_OFS_SELECT && !twelve) |=> RDATA == $past(sel_q);
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select readback differs from store");

    property p_mode_read;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR == cis_pkg::CIS_OFS_MODE) |=> (RDATA & 16'hFFF0) == 16'h0000;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback has stray bits");

    property p_idle_read;
        @(posedge CLK_SYS) disable iff (RST)
        !RD |=> RDATA == 16'h0000;
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data not zero without read");

    property p_unmapped_read;
        @(posedge CLK_SYS) disable iff (RST)
        (RD && ADDR > cis_pkg::CIS_OFS_MODE) |=> RDATA == 16'h0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    property p_store_mask;
        @(posedge CLK_SYS) disable iff (RST)
        (WR && ADDR == cis_pkg::CIS_OFS_SELECT) |=> (sel_q & 16'hF8F8) == 16'h0000;
    endproperty
    a_store_mask: assert property (p_store_mask) else $error("reserved select bits stored");

    property p_store_keep;
        @(posedge CLK_SYS) disable iff (RST)
        (WR && ADDR == cis_pkg::CIS_OFS_SELECT) |=> sel_q[10:8] == $past(WDATA[10:8]);
    endproperty
    a_store_keep: assert property (p_store_keep) else $error("mux B fields not stored");

endmodule : cis_select

// file: verification/cis_select_tb.sv
`timescale 1ns/100ps
module cis_select_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [47:0] held_q;
    cis_pkg::cis_route_s pa, na, pb, nb;
    int failures = 0;
    int cmp_count = 0;

    always #4 clk_sys = ~clk_sys;

    cis_select DUT (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .POS_ROUTE_A(pa), .NEG_ROUTE_A(na), .POS_ROUTE_B(pb), .NEG_ROUTE_B(nb));
    cis_sh_model sh (.clk(clk_sys), .pos_a(pa), .neg_a(na), .pos_b(pb), .neg_b(nb), .held_q(held_q));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Idle cycle after each transfer keeps strobes to one driver per step
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
        @(posedge clk_sys);
    endtask : bus

    function automatic logic [11:0] pos_exp(input logic s, input logic [3:1] o);
        pos_exp = s ? {o[1] ? 4'hC : 4'h3, o[2] ? 4'hD : 4'h0, o[3] ? 4'hE : 4'h6}
                    : {o[2] ? 4'hD : 4'h0, 4'h1, 4'h2};
    endfunction : pos_exp

    function automatic logic [11:0] neg_exp(input logic [1:0] n, input logic [3:1] o);
        neg_exp = (n == 2'h3) ? 12'h9AB : (n == 2'h2) ? {o[3] ? 4'hE : 4'h6, 4'h7, 4'h8} : 12'hFFF;
    endfunction : neg_exp

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [15:0] q;
        bus(1'b0, cis_pkg::CIS_OFS_SELECT, 16'h0000, q);
        check("select after reset", 48'h0, {32'h0, q});
        bus(1'b0, cis_pkg::CIS_OFS_MODE, 16'h0000, q);
        check("mode after reset", 48'h0, {32'h0, q});
        check("routes after reset", 48'h012FFF012FFF, held_q);
        $display("test reset done");
    endtask : t_reset

    task automatic t_unmapped;
        logic [15:0] q;
        bus(1'b1, 4'h7, 16'hFFFF, q);
        bus(1'b0, 4'h7, 16'h0000, q);
        check("unmapped read", 48'h0, {32'h0, q});
        bus(1'b0, cis_pkg::CIS_OFS_SELECT, 16'h0000, q);
        check("select untouched", 48'h0, {32'h0, q});
        $display("test unmapped done");
    endtask : t_unmapped

    // Every mode against every field code, junk in the empty bits
    task automatic t_decode;
        logic [15:0] q;
        logic [15:0] e;
        logic [3:0] m4;
        logic [2:0] k3;
        for (int m = 0; m < 16; m++) begin
            for (int k = 0; k < 8; k++) begin
                m4 = m[3:0];
                k3 = k[2:0];
                e = m4[0] ? 16'h0000 : {5'h00, k3, 5'h00, ~k3};
                bus(1'b1, cis_pkg::CIS_OFS_MODE, {12'h000, m4}, q);
                bus(1'b1, cis_pkg::CIS_OFS_SELECT, {5'h1F, k3, 5'h1F, ~k3}, q);
                bus(1'b0, cis_pkg::CIS_OFS_SELECT, 16'h0000, q);
                check("select readback", {32'h0, e}, {32'h0, q});
                bus(1'b0, cis_pkg::CIS_OFS_MODE, 16'h0000, q);
                check("mode readback", {32'h0, 12'h000, m4}, {32'h0, q});
                check("routes", {pos_exp(e[0], m4[3:1]), neg_exp(e[2:1], m4[3:1]),
                    pos_exp(e[8], m4[3:1]), neg_exp(e[10:9], m4[3:1])}, held_q);
            end
        end
        $display("test decode done");
    endtask : t_decode

    // Stored fields come back once 12-bit mode is left
    task automatic t_keep;
        logic [15:0] q;
        bus(1'b1, cis_pkg::CIS_OFS_SELECT, 16'h0707, q);
        bus(1'b1, cis_pkg::CIS_OFS_MODE, 16'h0001, q);
        bus(1'b0, cis_pkg::CIS_OFS_SELECT, 16'h0000, q);
        check("select hidden", 48'h0, {32'h0, q});
        bus(1'b1, cis_pkg::CIS_OFS_MODE, 16'h0000, q);
        bus(1'b0, cis_pkg::CIS_OFS_SELECT, 16'h0000, q);
        check("select kept", 48'h000000000707, {32'h0, q});
        $display("test keep done");
    endtask : t_keep

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_unmapped;
        t_decode;
        t_keep;
        print_verdict;
    end

    // Decode sweep needs about 8 us
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
endmodule : cis_select_tb

// file: verification/cis_sh_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Sample-and-hold front end
// ------------------------------------------------------------
// Only samples the routes, never drives them back
module cis_sh_model (
    input wire logic clk,
    input wire cis_pkg::cis_route_s pos_a,
    input wire cis_pkg::cis_route_s neg_a,
    input wire cis_pkg::cis_route_s pos_b,
    input wire cis_pkg::cis_route_s neg_b,
    output logic [47:0] held_q
);
    always_ff @(posedge clk) begin
        held_q <= {pos_a, neg_a, pos_b, neg_b};
    end
endmodule : cis_sh_model
